/* File: rtl/slm_pkg.sv */
// Package: constants, modes, states and carriers for the sensor logger mode controller
package slm_pkg;

    localparam int unsigned CLK_HZ = 40_000_000;

    localparam int unsigned INIT_TIME_MS = 10;
    localparam int unsigned ERASE_TIME_MS = 5000;
    localparam int unsigned RATE_SLOW_HZ = 40;
    localparam int unsigned RATE_FAST_HZ = 160;
    localparam int unsigned HB_SLOW_MS = 500;
    localparam int unsigned HB_FAST_MS = 250;
    localparam int unsigned BLINK_MS = 100;

    localparam int unsigned INIT_CYCLES = CLK_HZ / 1000 * INIT_TIME_MS;
    localparam int unsigned ERASE_CYCLES = CLK_HZ / 1000 * ERASE_TIME_MS;
    localparam int unsigned RATE_SLOW_CYCLES = CLK_HZ / RATE_SLOW_HZ;
    localparam int unsigned RATE_FAST_CYCLES = CLK_HZ / RATE_FAST_HZ;
    localparam int unsigned HB_SLOW_CYCLES = CLK_HZ / 1000 * HB_SLOW_MS;
    localparam int unsigned HB_FAST_CYCLES = CLK_HZ / 1000 * HB_FAST_MS;
    localparam int unsigned BLINK_CYCLES = CLK_HZ / 1000 * BLINK_MS;

    localparam int CNT_W = 32;

    // Log flash: 256 KB held as 16-bit words
    localparam int unsigned FLASH_BYTES = 262144;
    localparam int unsigned FLASH_WORDS = FLASH_BYTES / 2;
    localparam int ADDR_W = 17;
    localparam logic [ADDR_W-1:0] ADDR_LAST = 17'h1ffff;
    localparam logic [ADDR_W-1:0] ADDR_FIRST = 17'h00000;

    localparam int DATA_W = 16;
    localparam logic [DATA_W-1:0] FILL_WORD = 16'hffff;

    // Pin positions inside the synchroniser vector
    localparam int PIN_N = 4;
    localparam int PIN_FIRST = 0;
    localparam int PIN_SECOND = 1;
    localparam int PIN_THIRD = 2;
    localparam int PIN_SENSE = 3;

    typedef enum logic [1:0] {
        SLM_ONLINE = 2'h0,
        SLM_OFFLINE = 2'h1,
        SLM_READOUT = 2'h2
    } slm_mode_e;

    // Gray along init -> erase -> ready -> active
    typedef enum logic [1:0] {
        SLM_INIT = 2'h0,
        SLM_ERASE = 2'h1,
        SLM_READY = 2'h3,
        SLM_ACTIVE = 2'h2
    } slm_state_e;

    typedef enum logic {
        SLM_PKT_DATA = 1'h0,
        SLM_PKT_REGS = 1'h1
    } slm_pkt_e;

    typedef struct packed {
        slm_pkt_e kind;
        logic [DATA_W-1:0] data;
    } slm_usb_s;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } slm_flash_s;

endpackage

/* File: rtl/slm_mode_ctrl.sv */
// Module: operating-mode controller of the sensor logger, lamps, sample pacing and USB word buffer
// How it works
// RL1: green lamp blinks while samples are acquired
// RL2: digital module via serial bus, analogue via converter
// RL3: yellow lamp blinks while sending to host
// RL4: red lamp toggles each main loop pass
// RL5: all lamps lit in init, then off
// RL6: keys latched at init end choose mode
// RL7: offline mode erases whole flash before logging
// RL8: operator holds key before attaching unit
// RL9: online streams samples; first, second key ignored
// RL10: online third key sends register packet (digital)
// RL11: offline second key starts logging until full
// RL12: offline first key pauses; no key holds
// RL13: third key swaps 40/160 Hz before start
// RL14: red blink speed shows logging rate
// RL15: readout first key streams flash to host
// RL16: unwritten and past-end words sent as ones
// RL17: sense pin high digital, low analogue
// RL18: the two heartbeat speeds differ twofold
`timescale 1ns/100ps

module slm_mode_ctrl #(
    parameter int unsigned INIT_CYCLES = slm_pkg::INIT_CYCLES,
    parameter int unsigned ERASE_CYCLES = slm_pkg::ERASE_CYCLES,
    parameter int unsigned RATE_SLOW_CYCLES = slm_pkg::RATE_SLOW_CYCLES,
    parameter int unsigned RATE_FAST_CYCLES = slm_pkg::RATE_FAST_CYCLES,
    parameter int unsigned HB_SLOW_CYCLES = slm_pkg::HB_SLOW_CYCLES,
    parameter int unsigned HB_FAST_CYCLES = slm_pkg::HB_FAST_CYCLES,
    parameter int unsigned BLINK_CYCLES = slm_pkg::BLINK_CYCLES
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic first_key,
    input wire logic second_key,
    input wire logic third_key,
    input wire logic module_type_sense,
    output logic acq_req,
    output logic acq_regs,
    output logic acq_serial,
    input wire logic acq_valid,
    input wire logic [slm_pkg::DATA_W-1:0] acq_data,
    output logic flash_erase,
    input wire logic flash_erase_done,
    output logic flash_wr_valid,
    output slm_pkg::slm_flash_s flash_wr,
    input wire logic flash_wr_ready,
    output logic flash_rd_req,
    output logic [slm_pkg::ADDR_W-1:0] flash_rd_addr,
    input wire logic flash_rd_valid,
    input wire logic [slm_pkg::DATA_W-1:0] flash_rd_data,
    output logic usb_valid,
    output slm_pkg::slm_usb_s usb_word,
    input wire logic usb_ready,
    output logic green_read_indicator,
    output logic yellow_transfer_indicator,
    output logic red_heartbeat_indicator,
    output slm_pkg::slm_mode_e mode,
    output logic rate_fast,
    output logic log_full
);

    function automatic logic period_end(input logic [slm_pkg::CNT_W-1:0] cnt, input int unsigned period);
        period_end = (cnt >= slm_pkg::CNT_W'(period - 1));
    endfunction

    logic [slm_pkg::PIN_N-1:0] pin_raw, pin_meta, pin_sync, pin_prev, press;
    slm_pkg::slm_state_e state;
    logic digital, started, rate_tick, hb_tick, blink_tick, sample_due, regs_due, acq_busy, rd_busy, past_end;
    logic [slm_pkg::CNT_W-1:0] phase_cnt, rate_cnt, hb_cnt, blink_cnt;
    logic [slm_pkg::ADDR_W-1:0] wr_addr;
    logic skid_valid, buf_ready, buf_push, active_online, active_offline, active_readout;
    slm_pkg::slm_usb_s skid_word, buf_in;
    logic issue_regs, issue_sample, issue_read, push_fill, wr_done, init_end, erase_end;

    // Keys and the sense pin are asynchronous; two flops before any use
    assign pin_raw = {module_type_sense, third_key, second_key, first_key};

    genvar gi;
    generate
        for (gi = 0; gi < slm_pkg::PIN_N; gi++) begin : g_sync
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    pin_meta[gi] <= 1'b0;
                    pin_sync[gi] <= 1'b0;
                    pin_prev[gi] <= 1'b0;
                end else begin
                    pin_meta[gi] <= pin_raw[gi];
                    pin_sync[gi] <= pin_meta[gi];
                    pin_prev[gi] <= pin_sync[gi];
                end
            end
            assign press[gi] = pin_sync[gi] & ~pin_prev[gi];
        end
    endgenerate

    assign active_online = (state == slm_pkg::SLM_ACTIVE) && (mode == slm_pkg::SLM_ONLINE);
    assign active_offline = (state == slm_pkg::SLM_ACTIVE) && (mode == slm_pkg::SLM_OFFLINE);
    assign active_readout = (state == slm_pkg::SLM_ACTIVE) && (mode == slm_pkg::SLM_READOUT);
    assign init_end = (state == slm_pkg::SLM_INIT) && period_end(phase_cnt, INIT_CYCLES);
    assign erase_end = (state == slm_pkg::SLM_ERASE) && period_end(phase_cnt, ERASE_CYCLES) && flash_erase_done;
    assign wr_done = flash_wr_valid && flash_wr_ready;

    // One request in flight and a free skid entry guarantee room for the answer
    assign buf_ready = !skid_valid;
    assign issue_regs = active_online && regs_due && !acq_busy && buf_ready;
    assign issue_sample = sample_due && !acq_busy && !issue_regs
        && ((active_online && buf_ready) || (active_offline && !flash_wr_valid));
    assign issue_read = active_readout && !past_end && !rd_busy && buf_ready;
    assign push_fill = active_readout && past_end && buf_ready;

    always_comb begin
        buf_push = 1'b0;
        buf_in = '{kind: slm_pkg::SLM_PKT_DATA, data: slm_pkg::FILL_WORD};
        if (acq_valid && mode == slm_pkg::SLM_ONLINE) begin
            buf_push = 1'b1;
            buf_in = '{kind: acq_regs ? slm_pkg::SLM_PKT_REGS : slm_pkg::SLM_PKT_DATA, data: acq_data};
        end else if (flash_rd_valid) begin
            buf_push = 1'b1;
            buf_in = '{kind: slm_pkg::SLM_PKT_DATA, data: flash_rd_data};
        end else if (push_fill) begin
            buf_push = 1'b1; // see RL16
        end
    end

    // Mode, module type and state sequence
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= slm_pkg::SLM_INIT;
            mode <= slm_pkg::SLM_ONLINE;
            digital <= 1'b1;
            phase_cnt <= '0;
        end else begin
            phase_cnt <= phase_cnt + 1'b1;
            unique case (state)
                slm_pkg::SLM_INIT: begin
                    if (init_end) begin
                        phase_cnt <= '0;
                        digital <= pin_sync[slm_pkg::PIN_SENSE]; // see RL17
                        // Held keys count, not presses: the key is down before power-up; see RL8
                        if (pin_sync[slm_pkg::PIN_FIRST]) begin
                            mode <= slm_pkg::SLM_OFFLINE; // see RL6
                            state <= slm_pkg::SLM_ERASE; // see RL7
                        end else if (pin_sync[slm_pkg::PIN_SECOND]) begin
                            mode <= slm_pkg::SLM_READOUT; // see RL6
                            state <= slm_pkg::SLM_READY;
                        end else begin
                            mode <= slm_pkg::SLM_ONLINE; // see RL6
                            state <= slm_pkg::SLM_ACTIVE; // see RL9
                        end
                    end
                end
                slm_pkg::SLM_ERASE: begin
                    if (erase_end) begin
                        state <= slm_pkg::SLM_READY; // see RL7
                    end
                end
                slm_pkg::SLM_READY: begin
                    if (mode == slm_pkg::SLM_OFFLINE && press[slm_pkg::PIN_SECOND] && !log_full) begin
                        state <= slm_pkg::SLM_ACTIVE; // see RL11
                    end else if (mode == slm_pkg::SLM_READOUT && press[slm_pkg::PIN_FIRST]) begin
                        state <= slm_pkg::SLM_ACTIVE; // see RL15
                    end
                end
                slm_pkg::SLM_ACTIVE: begin
                    if (mode == slm_pkg::SLM_OFFLINE) begin
                        if (press[slm_pkg::PIN_FIRST]) begin
                            state <= slm_pkg::SLM_READY; // see RL12
                        end else if (wr_done && flash_wr.addr == slm_pkg::ADDR_LAST) begin
                            state <= slm_pkg::SLM_READY; // see RL11
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            flash_erase <= 1'b0;
        end else begin
            flash_erase <= (state == slm_pkg::SLM_ERASE) && !erase_end; // see RL7
        end
    end

    // Logging rate may only change before the first start
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rate_fast <= 1'b0;
            started <= 1'b0;
        end else begin
            if (active_offline) begin
                started <= 1'b1;
            end
            if (mode == slm_pkg::SLM_OFFLINE && state == slm_pkg::SLM_READY && !started
                    && press[slm_pkg::PIN_THIRD]) begin
                rate_fast <= !rate_fast; // see RL13
            end
        end
    end

    // Sample pacing: online runs at the fast rate
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rate_cnt <= '0;
        end else if (state != slm_pkg::SLM_ACTIVE || rate_tick) begin
            rate_cnt <= '0;
        end else begin
            rate_cnt <= rate_cnt + 1'b1;
        end
    end
    assign rate_tick = period_end(rate_cnt,
        (rate_fast || mode == slm_pkg::SLM_ONLINE) ? RATE_FAST_CYCLES : RATE_SLOW_CYCLES); // see RL13

    // A tick that lands while busy is kept, not lost
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sample_due <= 1'b0;
            regs_due <= 1'b0;
        end else begin
            if (rate_tick && (active_online || active_offline)) begin
                sample_due <= 1'b1;
            end else if (issue_sample || state != slm_pkg::SLM_ACTIVE) begin
                sample_due <= 1'b0;
            end
            if (active_online && digital && press[slm_pkg::PIN_THIRD]) begin
                regs_due <= 1'b1; // see RL10
            end else if (issue_regs) begin
                regs_due <= 1'b0;
            end
        end
    end

    // Sensor acquisition requests
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            acq_req <= 1'b0;
            acq_regs <= 1'b0;
            acq_serial <= 1'b1;
            acq_busy <= 1'b0;
        end else begin
            acq_req <= issue_regs || issue_sample;
            acq_serial <= digital; // see RL2
            if (issue_regs || issue_sample) begin
                acq_regs <= issue_regs; // see RL10
                acq_busy <= 1'b1;
            end else if (acq_valid) begin
                acq_busy <= 1'b0;
            end
        end
    end

    // Offline: each sample goes to the next flash word
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            flash_wr_valid <= 1'b0;
            flash_wr <= '0;
            wr_addr <= slm_pkg::ADDR_FIRST;
            log_full <= 1'b0;
        end else begin
            if (acq_valid && mode == slm_pkg::SLM_OFFLINE && !log_full) begin
                flash_wr_valid <= 1'b1; // see RL11
                flash_wr <= '{addr: wr_addr, data: acq_data};
            end else if (wr_done) begin
                flash_wr_valid <= 1'b0;
                wr_addr <= wr_addr + 1'b1;
                if (flash_wr.addr == slm_pkg::ADDR_LAST) begin
                    log_full <= 1'b1; // see RL11
                end
            end
        end
    end

    // Readout walks the whole flash, then keeps sending fill words
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            flash_rd_req <= 1'b0;
            flash_rd_addr <= slm_pkg::ADDR_FIRST;
            rd_busy <= 1'b0;
            past_end <= 1'b0;
        end else begin
            flash_rd_req <= issue_read; // see RL15
            if (issue_read) begin
                rd_busy <= 1'b1;
            end else if (flash_rd_valid) begin
                rd_busy <= 1'b0;
                if (flash_rd_addr == slm_pkg::ADDR_LAST) begin
                    past_end <= 1'b1; // see RL16
                end else begin
                    flash_rd_addr <= flash_rd_addr + 1'b1;
                end
            end
        end
    end

    // Two-entry buffer toward the host: output register plus skid entry
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            usb_valid <= 1'b0;
            usb_word <= '0;
            skid_valid <= 1'b0;
            skid_word <= '0;
        end else if (!usb_valid || usb_ready) begin
            if (skid_valid) begin
                usb_valid <= 1'b1;
                usb_word <= skid_word;
                skid_valid <= buf_push;
                skid_word <= buf_in;
            end else begin
                usb_valid <= buf_push; // see RL9
                usb_word <= buf_in;
            end
        end else if (buf_push) begin
            skid_valid <= 1'b1;
            skid_word <= buf_in;
        end
    end

    // Heartbeat period: slow normally, fast only for the 160 Hz logging rate
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hb_cnt <= '0;
            blink_cnt <= '0;
        end else begin
            hb_cnt <= hb_tick ? '0 : hb_cnt + 1'b1;
            blink_cnt <= blink_tick ? '0 : blink_cnt + 1'b1;
        end
    end
    assign hb_tick = period_end(hb_cnt,
        (mode == slm_pkg::SLM_OFFLINE && rate_fast) ? HB_FAST_CYCLES : HB_SLOW_CYCLES); // see RL14, RL18
    assign blink_tick = period_end(blink_cnt, BLINK_CYCLES);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            green_read_indicator <= 1'b1;
            yellow_transfer_indicator <= 1'b1;
            red_heartbeat_indicator <= 1'b1;
        end else if (state == slm_pkg::SLM_INIT) begin
            green_read_indicator <= !init_end; // see RL5
            yellow_transfer_indicator <= !init_end; // see RL5
            red_heartbeat_indicator <= !init_end; // see RL5
        end else begin
            if (hb_tick) begin
                red_heartbeat_indicator <= !red_heartbeat_indicator; // see RL4
            end
            if (!(active_online || active_offline)) begin
                green_read_indicator <= 1'b0;
            end else if (blink_tick) begin
                green_read_indicator <= !green_read_indicator; // see RL1
            end
            if (!(active_online || active_readout || usb_valid)) begin
                yellow_transfer_indicator <= 1'b0;
            end else if (blink_tick) begin
                yellow_transfer_indicator <= !yellow_transfer_indicator; // see RL3
            end
        end
    end

endmodule

/* File: verif/slm_mode_ctrl_properties.sv */
// Checker: port timing relations of the mode controller
`timescale 1ns/100ps
module slm_mode_ctrl_properties #(
    parameter int unsigned INIT_CYCLES = 20
) (
    input logic clk,
    input logic rst,
    input logic module_type_sense,
    input logic acq_req,
    input logic acq_regs,
    input logic acq_serial,
    input logic acq_valid,
    input logic flash_erase,
    input logic flash_wr_valid,
    input slm_pkg::slm_flash_s flash_wr,
    input logic flash_wr_ready,
    input logic flash_rd_req,
    input logic usb_valid,
    input slm_pkg::slm_usb_s usb_word,
    input logic usb_ready,
    input logic green_read_indicator,
    input logic yellow_transfer_indicator,
    input logic red_heartbeat_indicator,
    input slm_pkg::slm_mode_e mode
);
    logic [15:0] cyc;
    logic outst;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // Saturates: never wraps back into init
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cyc <= 16'h0000;
        end else if (cyc != 16'hffff) begin
            cyc <= cyc + 16'h0001;
        end
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            outst <= 1'b0;
        end else if (acq_req) begin
            outst <= 1'b1;
        end else if (acq_valid) begin
            outst <= 1'b0;
        end
    end
    a_init_lamps_lit: assert property (int'(cyc) < INIT_CYCLES - 2 |->
        green_read_indicator && yellow_transfer_indicator && red_heartbeat_indicator) else $error("lamps dark in init");
    a_init_end_dark: assert property (int'(cyc) == INIT_CYCLES + 2 |-> !red_heartbeat_indicator)
        else $error("red lit after init");
    a_mode_held: assert property (int'(cyc) > INIT_CYCLES + 2 |-> $stable(mode)) else $error("mode changed");
    a_one_outstanding: assert property (acq_req |-> !outst) else $error("second request");
    a_sense_path: assert property (int'(cyc) > INIT_CYCLES + 2 |-> acq_serial == module_type_sense)
        else $error("wrong path");
    a_regs_digital: assert property (acq_req && acq_regs |-> acq_serial && mode == slm_pkg::SLM_ONLINE)
        else $error("bad register read");
    a_erase_first: assert property (flash_erase |-> mode == slm_pkg::SLM_OFFLINE && !flash_wr_valid)
        else $error("erase overlaps write");
    a_write_offline: assert property (flash_wr_valid |-> mode == slm_pkg::SLM_OFFLINE)
        else $error("write outside offline");
    a_read_readout: assert property (flash_rd_req |-> mode == slm_pkg::SLM_READOUT)
        else $error("read outside readout");
    a_usb_word_held: assert property (usb_valid && !usb_ready |=> usb_valid && $stable(usb_word))
        else $error("usb word dropped");
    a_wr_word_held: assert property (flash_wr_valid && !flash_wr_ready |=> flash_wr_valid && $stable(flash_wr))
        else $error("write dropped");
endmodule

/* File: verif/slm_partner.sv */
// Partner model: sensor, log flash and USB host
`timescale 1ns/100ps
module slm_partner (
    input logic clk,
    input logic host_stall,
    input logic acq_req,
    input logic acq_regs,
    output logic acq_valid,
    output logic [slm_pkg::DATA_W-1:0] acq_data,
    input logic flash_erase,
    output logic flash_erase_done,
    input logic flash_wr_valid,
    input slm_pkg::slm_flash_s flash_wr,
    output logic flash_wr_ready,
    input logic flash_rd_req,
    input logic [slm_pkg::ADDR_W-1:0] flash_rd_addr,
    output logic flash_rd_valid,
    output logic [slm_pkg::DATA_W-1:0] flash_rd_data,
    output logic usb_ready
);
    logic [slm_pkg::DATA_W-1:0] mem [int];
    logic [7:0] n = 8'h00;
    logic [1:0] wait_cnt = 2'h0;
    logic [2:0] erase_cnt = 3'h0;
    logic regs = 1'b0;
    initial begin
        {acq_valid, acq_data, flash_erase_done, flash_wr_ready, flash_rd_valid, flash_rd_data, usb_ready} = '0;
    end
    // Answers come after 2 or 3 cycles; data lines churn between answers
    always @(posedge clk) begin
        acq_valid <= 1'b0;
        acq_data <= ~acq_data;
        if (acq_req) begin
            wait_cnt <= {1'b1, n[0]};
            regs <= acq_regs;
        end else if (wait_cnt != 2'h0) begin
            wait_cnt <= wait_cnt - 2'h1;
            if (wait_cnt == 2'h1) begin
                acq_valid <= 1'b1;
                acq_data <= {regs ? 8'ha5 : 8'h3c, n};
                n <= n + 8'h01;
            end
        end
    end
    // Flash accepts every other cycle; erased words read as all ones
    always @(posedge clk) begin
        flash_wr_ready <= ~flash_wr_ready;
        flash_rd_valid <= flash_rd_req;
        flash_rd_data <= ~flash_rd_data;
        erase_cnt <= flash_erase ? erase_cnt + {2'h0, erase_cnt != 3'h7} : 3'h0;
        flash_erase_done <= erase_cnt == 3'h7;
        if (flash_erase) begin
            mem.delete();
        end
        if (flash_wr_valid && flash_wr_ready) begin
            mem[int'(flash_wr.addr)] = flash_wr.data;
        end
        if (flash_rd_req) begin
            flash_rd_data <= mem.exists(int'(flash_rd_addr)) ? mem[int'(flash_rd_addr)] : 16'hffff;
        end
        usb_ready <= !host_stall && !usb_ready;
    end
endmodule

/* File: verif/slm_mode_ctrl_tb_top.sv */
// Testbench: mode selection, streaming, logging and readout
`timescale 1ns/100ps
`define CHK(name, exp, got) begin \
    tests_run++; \
    if ((got) !== (exp)) begin \
        err_total++; \
        $display("wrong value %s exp %h got %h", name, exp, got); \
    end \
end
module slm_mode_ctrl_tb_top;
    localparam int unsigned INIT_C = 20;
    logic clk = 1'b0, rst = 1'b1, sense = 1'b1, host_stall = 1'b0;
    logic [2:0] keys = 3'h0;
    logic acq_req, acq_regs, acq_serial, acq_valid, flash_erase, flash_erase_done, flash_wr_valid, flash_wr_ready;
    logic flash_rd_req, flash_rd_valid, usb_valid, usb_ready, green, yellow, red, rate_fast, log_full;
    logic [15:0] acq_data, flash_rd_data;
    logic [16:0] flash_rd_addr;
    slm_pkg::slm_flash_s flash_wr;
    slm_pkg::slm_usb_s usb_word;
    slm_pkg::slm_mode_e mode;
    slm_pkg::slm_usb_s q[$];
    logic [15:0] wlog[$];
    int err_total = 0, tests_run = 0, g_rise = 0, y_rise = 0, gap = 0, hcnt = 0, n = 0, found = 0;
    initial forever #12.5 clk = ~clk;
    slm_mode_ctrl #(.INIT_CYCLES(INIT_C), .ERASE_CYCLES(30), .RATE_FAST_CYCLES(10), .HB_SLOW_CYCLES(16),
        .HB_FAST_CYCLES(8), .BLINK_CYCLES(4)) i_slm_mode_ctrl (.clk, .rst, .first_key(keys[0]),
        .second_key(keys[1]), .third_key(keys[2]), .module_type_sense(sense), .acq_req, .acq_regs, .acq_serial,
        .acq_valid, .acq_data, .flash_erase, .flash_erase_done, .flash_wr_valid, .flash_wr, .flash_wr_ready,
        .flash_rd_req, .flash_rd_addr, .flash_rd_valid, .flash_rd_data, .usb_valid, .usb_word, .usb_ready,
        .green_read_indicator(green), .yellow_transfer_indicator(yellow), .red_heartbeat_indicator(red), .mode,
        .rate_fast, .log_full);
    slm_partner i_slm_partner (.clk, .host_stall, .acq_req, .acq_regs, .acq_valid, .acq_data, .flash_erase,
        .flash_erase_done, .flash_wr_valid, .flash_wr, .flash_wr_ready, .flash_rd_req, .flash_rd_addr,
        .flash_rd_valid, .flash_rd_data, .usb_ready);
    always @(posedge clk) begin
        if (usb_valid && usb_ready) q.push_back(usb_word);
        if (flash_wr_valid && flash_wr_ready) begin
            `CHK("wr addr", 17'(wlog.size()), flash_wr.addr)
            wlog.push_back(flash_wr.data);
        end
        g_rise += int'($rose(green));
        y_rise += int'($rose(yellow));
        if ($changed(red)) begin
            gap = hcnt;
            hcnt = 1;
        end else begin
            hcnt++;
        end
    end
    task automatic wt(input int c);
        repeat (c) @(posedge clk);
    endtask
    task automatic run_reset(input logic [2:0] k, input logic s);
        @(posedge clk);
        rst <= 1'b1;
        keys <= k;
        sense <= s;
        wt(10);
        rst <= 1'b0;
        wt(5);
        `CHK("init lamps", 3'b111, {green, yellow, red})
        wt(INIT_C);
        keys <= 3'h0;
        wt(4);
        q.delete();
        g_rise = 0;
        y_rise = 0;
    endtask
    task automatic press(input int k);
        @(posedge clk);
        keys[k] <= 1'b1;
        wt(6);
        keys[k] <= 1'b0;
        wt(4);
    endtask
    task automatic t_online;
        run_reset(3'b000, 1'b1);
        `CHK("mode", slm_pkg::SLM_ONLINE, mode)
        `CHK("serial", 1'b1, acq_serial)
        press(0);
        press(1);
        wt(60);
        `CHK("mode kept", slm_pkg::SLM_ONLINE, mode)
        `CHK("streamed", 1'b1, q.size() > 0)
        `CHK("kind", slm_pkg::SLM_PKT_DATA, q[0].kind)
        `CHK("sample", 8'h3c, q[0].data[15:8])
        `CHK("green", 1'b1, g_rise > 0)
        `CHK("yellow", 1'b1, y_rise > 0)
        `CHK("red gap", 16, gap)
        // A stalled host must not drop any acquired sample from the stream
        host_stall <= 1'b1;
        wt(60);
        host_stall <= 1'b0;
        wt(40);
        for (int i = 1; i < q.size(); i++) `CHK("sequence", q[i - 1].data[7:0] + 8'h01, q[i].data[7:0])
        press(2);
        wt(40);
        found = 0;
        foreach (q[i]) if (q[i].kind === slm_pkg::SLM_PKT_REGS && q[i].data[15:8] === 8'ha5) found = 1;
        `CHK("reg packet", 1, found)
    endtask
    task automatic t_offline;
        run_reset(3'b001, 1'b1);
        wlog.delete();
        `CHK("mode", slm_pkg::SLM_OFFLINE, mode)
        `CHK("erasing", 1'b1, flash_erase)
        for (int i = 0; i < 200 && flash_erase !== 1'b0; i++) @(posedge clk);
        `CHK("erase end", 1'b0, flash_erase)
        `CHK("no early write", 0, wlog.size())
        `CHK("rate slow", 1'b0, rate_fast)
        press(2);
        `CHK("rate fast", 1'b1, rate_fast)
        press(1);
        wt(80);
        `CHK("logging", 1'b1, wlog.size() > 0)
        `CHK("not full", 1'b0, log_full)
        `CHK("logged word", 8'h3c, wlog[0][15:8])
        `CHK("green", 1'b1, g_rise > 0)
        `CHK("red fast", 8, gap)
        press(2);
        `CHK("rate locked", 1'b1, rate_fast)
        press(0);
        wt(20);
        n = wlog.size();
        wt(80);
        `CHK("paused", n, wlog.size())
        press(1);
        wt(40);
        `CHK("resumed", 1'b1, wlog.size() > n)
        press(0);
        wt(20);
    endtask
    task automatic t_readout;
        run_reset(3'b010, 1'b0);
        `CHK("mode", slm_pkg::SLM_READOUT, mode)
        `CHK("converter", 1'b0, acq_serial)
        press(2);
        press(1);
        wt(20);
        `CHK("idle", 0, q.size())
        press(0);
        wt(100);
        `CHK("sending", 1'b1, q.size() > wlog.size())
        `CHK("yellow", 1'b1, y_rise > 0)
        foreach (q[i]) `CHK("readout", i < wlog.size() ? wlog[i] : 16'hffff, q[i].data)
    endtask
    task automatic complete_run;
        if (err_total == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        t_online;
        t_offline;
        t_readout;
        complete_run;
    end
    // Run needs ~830 cycles; 4000 means a hang
    initial begin
        #100000;
        err_total++;
        complete_run;
    end
endmodule
bind slm_mode_ctrl slm_mode_ctrl_properties #(.INIT_CYCLES(INIT_CYCLES)) i_slm_mode_ctrl_properties (.clk, .rst,
    .module_type_sense, .acq_req, .acq_regs, .acq_serial, .acq_valid, .flash_erase, .flash_wr_valid, .flash_wr,
    .flash_wr_ready, .flash_rd_req, .usb_valid, .usb_word, .usb_ready, .green_read_indicator,
    .yellow_transfer_indicator, .red_heartbeat_indicator, .mode);
